//--- src/mfp_map.svh
// register map, field positions and timing constants of the fault-protection block
`ifndef MFP_MAP_SVH
`define MFP_MAP_SVH
`define MFP_ADDR_W 8
`define MFP_ADDR_CTRL 8'h00
`define MFP_ADDR_DEV 8'h04
`define MFP_ADDR_SUP 8'h08
`define MFP_ADDR_THERM 8'h0C
`define MFP_HSIZE_WORD 3'h2
`define MFP_CTRL_W 12
`define MFP_CTRL_RST 12'h009
`define MFP_C_OCPM 2:0
`define MFP_C_OTSDM 4:3
`define MFP_C_REFEN 5
`define MFP_C_OTWEN 6
`define MFP_C_DEG 8:7
`define MFP_C_BLANK 10:9
`define MFP_C_THR 11
`define MFP_C_CLR 12
`define MFP_OCPM_SLOW 3'h0
`define MFP_OCPM_FAST 3'h1
`define MFP_OCPM_LATCH 3'h2
`define MFP_OCPM_REPORT 3'h3
`define MFP_OCPM_OFF 3'h7
`define MFP_OTSDM_FAST 2'h1
`define MFP_CLK_KHZ 25000
`define MFP_DEG_NS 1000
`define MFP_BLANK_NS 200
`define MFP_DEG_CYC ((`MFP_DEG_NS * `MFP_CLK_KHZ + 999999) / 1000000)
`define MFP_BLANK_CYC ((`MFP_BLANK_NS * `MFP_CLK_KHZ + 999999) / 1000000)
`define MFP_FAST_RETRY_MS 5
`define MFP_SLOW_RETRY_MS 10
`define MFP_SLEEP_US 100
`define MFP_WAKE_US 100
`define MFP_RST_US 20
`endif

//--- src/mfp_pkg.sv
// types of the fault-protection block
package mfp_pkg;
   typedef enum logic [1:0] {
      ST_ACT,
      ST_LOW,
      ST_SLEEP,
      ST_WAKE
   } mfp_pwr_type;
endpackage

//--- src/mfp_top.sv
// fault-protection and power-mode controller with its retry timers
`timescale 1ns/1ps
`default_nettype none
`include "mfp_map.svh"

module mfp_retry #(
   parameter int W = 20
) (
   // clock and control
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // trigger, holding condition, interval
   input wire logic trig,
   input wire logic hold,
   input wire logic [W-1:0] lim,
   // state
   output logic active,
   output logic done
);
   logic [W-1:0] cnt_r;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         active <= 1'b0;
         done <= 1'b0;
         cnt_r <= '0;
      end else if (ce) begin
         done <= 1'b0;
         if (trig) begin
            active <= 1'b1;
            cnt_r <= '0;
         end else if (active) begin
            if (hold) begin
               cnt_r <= '0;
            end else if (cnt_r >= lim - W'(1)) begin
               active <= 1'b0;
               done <= 1'b1;
               cnt_r <= '0;
            end else begin
               cnt_r <= cnt_r + W'(1);
            end
         end
      end
   end
endmodule

module mfp_top
   import mfp_pkg::*;
#(
   parameter int unsigned FAST_RETRY_CYC = `MFP_FAST_RETRY_MS * `MFP_CLK_KHZ,
   parameter int unsigned SLOW_RETRY_CYC = `MFP_SLOW_RETRY_MS * `MFP_CLK_KHZ,
   parameter int unsigned SLEEP_CYC = `MFP_SLEEP_US * `MFP_CLK_KHZ / 1000,
   parameter int unsigned WAKE_CYC = `MFP_WAKE_US * `MFP_CLK_KHZ / 1000,
   parameter int unsigned RST_CYC = `MFP_RST_US * `MFP_CLK_KHZ / 1000,
   parameter int NFET = 6
) (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // straps
   input wire logic hw_variant_in,
   input wire logic mode_pin_in,
   // comparators, pwm and sleep pin
   input wire logic sense_ref_low_flag_in,
   input wire logic pump_low_flag_in,
   input wire logic [NFET-1:0] ocp_in,
   input wire logic otw_in,
   input wire logic thermal_shutdown_flag_in,
   input wire logic [NFET-1:0] pwm_in,
   input wire logic sleep_in_n,
   // power enables and overcurrent threshold select
   output logic fet_en,
   output logic cp_en,
   output logic csa_en,
   output logic ldo_en,
   output logic spi_en,
   output logic overcurrent_threshold_sel,
   // open-drain fault pin
   output logic fault_out_n_o,
   output logic fault_out_n_oe
);
   localparam int RW = 20;
   logic [`MFP_CTRL_W-1:0] ctrl_r;
   logic clr_cmd_r, rst_pulse_r, clr;
   logic hw_r, strap_done_r;
   logic wr_pend_r;
   logic [`MFP_ADDR_W-1:0] wr_addr_r;
   logic [31:0] rd_mux;
   mfp_pwr_type st_r;
   logic [RW-1:0] pcnt_r;
   logic [NFET-1:0] pwm_q_r, ocp_evt, ocp_set, fet_ocp_r;
   logic [7:0] blank_cnt_r, deg_lim, blank_lim;
   logic [7:0] deg_cnt_r [NFET];
   logic blanking, acc;
   logic [2:0] ocpm;
   logic [1:0] otsdm;
   logic ref_cond, otw_rep, retry_mode, ocp_hold;
   logic csa_act, cp_act, thermal_shutdown_flag_act, ocp_act, ocp_done;
   logic fault_r, uv_r, ocp_r, ot_r;
   logic run, pin_hold, fault_any;

   // strap capture after reset release
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         hw_r <= 1'b0;
         strap_done_r <= 1'b0;
      end else if (ce && !strap_done_r) begin
         hw_r <= hw_variant_in;
         strap_done_r <= 1'b1;
      end
   end

   // effective configuration
   assign ocpm = hw_r ? `MFP_OCPM_FAST : ctrl_r[`MFP_C_OCPM];
   assign otsdm = hw_r ? `MFP_OTSDM_FAST : ctrl_r[`MFP_C_OTSDM];
   assign ref_cond = !hw_r && ctrl_r[`MFP_C_REFEN] && sense_ref_low_flag_in;
   assign otw_rep = !hw_r && ctrl_r[`MFP_C_OTWEN];
   assign deg_lim = hw_r ? 8'(`MFP_DEG_CYC) :
                    8'(`MFP_DEG_CYC * (int'(ctrl_r[`MFP_C_DEG]) + 1));
   assign blank_lim = hw_r ? 8'(`MFP_BLANK_CYC) :
                      8'(`MFP_BLANK_CYC * (int'(ctrl_r[`MFP_C_BLANK]) + 1));
   assign retry_mode = (ocpm == `MFP_OCPM_SLOW) || (ocpm == `MFP_OCPM_FAST);
   assign clr = clr_cmd_r || rst_pulse_r;

   // ahb-lite slave, zero wait states
   assign acc = hsel && hready && htrans[1];
   always_comb begin
      rd_mux = 32'h0;
      case (haddr[`MFP_ADDR_W-1:0])
         `MFP_ADDR_CTRL: rd_mux[`MFP_CTRL_W-1:0] = ctrl_r;
         `MFP_ADDR_DEV: rd_mux = {18'h0, fet_ocp_r, 3'h0, st_r == ST_SLEEP,
                                  ot_r, ocp_r, uv_r, fault_r};
         `MFP_ADDR_SUP: rd_mux = {30'h0, cp_act, csa_act};
         `MFP_ADDR_THERM: rd_mux = {30'h0, thermal_shutdown_flag_act, otw_in};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_r <= acc && hwrite && hsize == `MFP_HSIZE_WORD;
         wr_addr_r <= haddr[`MFP_ADDR_W-1:0];
         hrdata <= (acc && !hwrite) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctrl_r <= `MFP_CTRL_RST;
         clr_cmd_r <= 1'b0;
      end else if (ce) begin
         clr_cmd_r <= 1'b0;
         if (wr_pend_r && wr_addr_r == `MFP_ADDR_CTRL) begin
            ctrl_r <= hwdata[`MFP_CTRL_W-1:0];
            clr_cmd_r <= hwdata[`MFP_C_CLR];
         end
      end
   end

   // sleep pin sequencing
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_r <= ST_ACT;
         pcnt_r <= '0;
         rst_pulse_r <= 1'b0;
      end else if (ce) begin
         rst_pulse_r <= 1'b0;
         case (st_r)
            ST_ACT: begin
               pcnt_r <= '0;
               if (!sleep_in_n) st_r <= ST_LOW;
            end
            ST_LOW: begin
               if (sleep_in_n) begin
                  rst_pulse_r <= pcnt_r < RW'(RST_CYC);
                  st_r <= ST_ACT;
               end else if (pcnt_r >= RW'(SLEEP_CYC - 1)) begin
                  st_r <= ST_SLEEP;
               end else begin
                  pcnt_r <= pcnt_r + RW'(1);
               end
            end
            ST_SLEEP: begin
               pcnt_r <= '0;
               if (sleep_in_n) st_r <= ST_WAKE;
            end
            ST_WAKE: begin
               if (!sleep_in_n) begin
                  st_r <= ST_LOW;
                  pcnt_r <= '0;
               end else if (pcnt_r >= RW'(WAKE_CYC - 1)) begin
                  st_r <= ST_ACT;
               end else begin
                  pcnt_r <= pcnt_r + RW'(1);
               end
            end
            default: st_r <= ST_ACT;
         endcase
      end
   end

   // pwm edge blanking
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pwm_q_r <= '0;
         blank_cnt_r <= 8'h0;
      end else if (ce) begin
         pwm_q_r <= pwm_in;
         if (|(pwm_in ^ pwm_q_r)) blank_cnt_r <= blank_lim;
         else if (blank_cnt_r != 8'h0) blank_cnt_r <= blank_cnt_r - 8'h1;
      end
   end
   assign blanking = (|(pwm_in ^ pwm_q_r)) || blank_cnt_r != 8'h0;

   // per-fet deglitch
   for (genvar gi = 0; gi < NFET; gi++) begin : g_deg
      always_ff @(posedge core_clk) begin
         if (!nrst) begin
            deg_cnt_r[gi] <= 8'h0;
         end else if (ce) begin
            if (!ocp_in[gi] || blanking) deg_cnt_r[gi] <= 8'h0;
            else if (deg_cnt_r[gi] != deg_lim) deg_cnt_r[gi] <= deg_cnt_r[gi] + 8'h1;
         end
      end
      assign ocp_evt[gi] = ocp_in[gi] && !blanking && deg_cnt_r[gi] == deg_lim - 8'h1;
   end
   assign ocp_set = (ocpm == `MFP_OCPM_OFF) ? '0 : ocp_evt;
   assign ocp_hold = !retry_mode && (|ocp_in);

   // retry timers
   mfp_retry #(.W(RW)) u_ref (
      .clk(core_clk), .nrst(nrst), .ce(ce), .trig(ref_cond), .hold(ref_cond),
      .lim(RW'(FAST_RETRY_CYC)), .active(csa_act), .done());
   mfp_retry #(.W(RW)) u_cp (
      .clk(core_clk), .nrst(nrst), .ce(ce), .trig(pump_low_flag_in), .hold(pump_low_flag_in),
      .lim(RW'(FAST_RETRY_CYC)), .active(cp_act), .done());
   mfp_retry #(.W(RW)) u_ot (
      .clk(core_clk), .nrst(nrst), .ce(ce), .trig(thermal_shutdown_flag_in), .hold(thermal_shutdown_flag_in),
      .lim(otsdm == `MFP_OTSDM_FAST ? RW'(FAST_RETRY_CYC) : RW'(SLOW_RETRY_CYC)),
      .active(thermal_shutdown_flag_act), .done());
   mfp_retry #(.W(RW)) u_ocp (
      .clk(core_clk), .nrst(nrst), .ce(ce), .trig(retry_mode && (|ocp_set)),
      .hold(1'b0),
      .lim(ocpm == `MFP_OCPM_FAST ? RW'(FAST_RETRY_CYC) : RW'(SLOW_RETRY_CYC)),
      .active(ocp_act), .done(ocp_done));

   // status flags, set wins over clear
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         fet_ocp_r <= '0;
      end else if (ce) begin
         if ((retry_mode && ocp_done) || (!retry_mode && clr && !(|ocp_in)))
            fet_ocp_r <= ocp_set;
         else
            fet_ocp_r <= fet_ocp_r | ocp_set;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         fault_r <= 1'b0;
         uv_r <= 1'b0;
         ocp_r <= 1'b0;
         ot_r <= 1'b0;
      end else if (ce) begin
         if (ref_cond || pump_low_flag_in || (|ocp_set) || thermal_shutdown_flag_in) fault_r <= 1'b1;
         else if (clr && !ocp_hold) fault_r <= 1'b0;
         if (ref_cond || pump_low_flag_in) uv_r <= 1'b1;
         else if (clr) uv_r <= 1'b0;
         if (|ocp_set) ocp_r <= 1'b1;
         else if (clr && !ocp_hold) ocp_r <= 1'b0;
         if (otw_in || thermal_shutdown_flag_in) ot_r <= 1'b1;
         else if (clr && !otw_in) ot_r <= 1'b0;
      end
   end

   // outputs
   assign run = st_r == ST_ACT || st_r == ST_LOW;
   assign pin_hold = (st_r == ST_LOW && pcnt_r >= RW'(RST_CYC)) || st_r == ST_WAKE;
   assign fault_any = st_r != ST_SLEEP && (csa_act || cp_act || thermal_shutdown_flag_act ||
                      (|fet_ocp_r) || (otw_in && otw_rep) || pin_hold);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         fet_en <= 1'b0;
         cp_en <= 1'b0;
         csa_en <= 1'b0;
         ldo_en <= 1'b0;
         spi_en <= 1'b0;
         overcurrent_threshold_sel <= 1'b0;
         fault_out_n_o <= 1'b0;
         fault_out_n_oe <= 1'b0;
      end else if (ce) begin
         fet_en <= run && !cp_act && !thermal_shutdown_flag_act &&
                   !((|fet_ocp_r) && ocpm != `MFP_OCPM_REPORT);
         cp_en <= st_r != ST_SLEEP && !cp_act && !thermal_shutdown_flag_act;
         csa_en <= run && !csa_act;
         ldo_en <= st_r != ST_SLEEP;
         spi_en <= st_r != ST_SLEEP;
         overcurrent_threshold_sel <= hw_r ? mode_pin_in : ctrl_r[`MFP_C_THR];
         fault_out_n_o <= 1'b0;
         fault_out_n_oe <= fault_any;
      end
   end

   // checks
   chk_ref_sense_off: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      csa_act |=> !csa_en) else $error("sense amps on during reference low");
   chk_pump_fet_off: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      cp_act |=> !fet_en && !cp_en) else $error("driver on during pump low");
   chk_uv_hold: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      uv_r && !clr |=> uv_r) else $error("undervoltage bit dropped without clear");
   chk_uv_clear: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      clr && !ref_cond && !pump_low_flag_in |=> !uv_r) else $error("undervoltage bit not cleared");
   chk_ocp_off_mode: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      ocpm == `MFP_OCPM_OFF && !ocp_r |=> !ocp_r) else $error("overcurrent set while off");
   chk_blank_ignore: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      blanking |-> ocp_evt == '0) else $error("overcurrent taken during blanking");
   chk_thermal_shutdown_flag_off: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      thermal_shutdown_flag_act |=> !fet_en && !cp_en && fault_out_n_oe) else $error("shutdown not applied");
   chk_sleep_off: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      st_r == ST_SLEEP |=> !ldo_en && !spi_en && !fet_en) else $error("supplies on in sleep");
   chk_wake_hold: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      $rose(st_r == ST_WAKE) |=> fault_out_n_oe [*2]) else $error("fault pin free on wake");
   chk_report_drive: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
      ocpm == `MFP_OCPM_REPORT && run && !cp_act && !thermal_shutdown_flag_act && (|fet_ocp_r)
      |=> fet_en && fault_out_n_oe) else $error("report mode stopped driver");
endmodule
`default_nettype wire

//--- tb/mfp_ctrl_model.sv
// external controller model: drives the sleep pin, watches the fault pin
`timescale 1ns/1ps
`default_nettype none
module mfp_ctrl_model (
   // clock
   input wire logic clk,
   // fault pin as driven by the device
   input wire logic fault_out_n_o,
   input wire logic fault_out_n_oe,
   // pin levels
   output logic sleep_in_n,
   output logic fault_n
);
   // pull-up holds the released pin high
   assign fault_n = fault_out_n_oe ? fault_out_n_o : 1'b1;
   initial sleep_in_n = 1'b1;
   task automatic set_sleep(input logic v);
      @(posedge clk);
      sleep_in_n <= v;
   endtask
   // high-low-high pulse; a short low phase clears latched faults
   task automatic reset_pulse(input int n);
      set_sleep(1'b0);
      repeat (n) @(posedge clk);
      sleep_in_n <= 1'b1;
      repeat (20) @(posedge clk); // wake time passes before next input
   endtask
endmodule
`default_nettype wire

//--- tb/mfp_top_test.sv
// self-checking bench of the fault-protection block
`timescale 1ns/1ps
`default_nettype none
`include "mfp_map.svh"
module mfp_top_test;
   import mfp_pkg::*;
   logic core_clk, nrst, hsel, hwrite, hrdyo, hresp, otw_in, thermal_shutdown_flag_in, sense_ref_low_flag_in, pump_low_flag_in;
   logic fet_en, cp_en, csa_en, ldo_en, spi_en, thr, flt_o, flt_oe, sleep_in_n, fault_n;
   logic ce, hw_variant_in, mode_pin_in;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [5:0] ocp_in, pwm_in, en;
   int bad_count, check_count;
   logic [2:0] modes[5] = '{`MFP_OCPM_LATCH, `MFP_OCPM_REPORT, `MFP_OCPM_OFF, `MFP_OCPM_FAST,
      `MFP_OCPM_SLOW};
   logic [5:0] en1[5] = '{6'h1E, 6'h3E, 6'h3F, 6'h1E, 6'h1E};
   logic [5:0] en2[5] = '{6'h1E, 6'h3E, 6'h3F, 6'h3F, 6'h3F};
   logic [31:0] dv1[5] = '{32'h105, 32'h105, 32'h0, 32'h105, 32'h105};
   logic [31:0] dv2[5] = '{32'h105, 32'h105, 32'h0, 32'h5, 32'h5};
   assign en = {fet_en, cp_en, csa_en, ldo_en, spi_en, fault_n};
   mfp_top #(.FAST_RETRY_CYC(20), .SLOW_RETRY_CYC(40), .SLEEP_CYC(16), .WAKE_CYC(16),
      .RST_CYC(4)) dut (.core_clk(core_clk), .nrst(nrst), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hrdyo), .hrdata(hrdata), .hreadyout(hrdyo), .hresp(hresp),
      .hw_variant_in(hw_variant_in), .mode_pin_in(mode_pin_in), .sense_ref_low_flag_in(sense_ref_low_flag_in),
      .pump_low_flag_in(pump_low_flag_in), .ocp_in(ocp_in), .otw_in(otw_in), .thermal_shutdown_flag_in(thermal_shutdown_flag_in),
      .pwm_in(pwm_in), .sleep_in_n(sleep_in_n), .fet_en(fet_en), .cp_en(cp_en),
      .csa_en(csa_en), .ldo_en(ldo_en), .spi_en(spi_en), .overcurrent_threshold_sel(thr),
      .fault_out_n_o(flt_o), .fault_out_n_oe(flt_oe));
   mfp_ctrl_model ctl (.clk(core_clk), .fault_out_n_o(flt_o), .fault_out_n_oe(flt_oe),
      .sleep_in_n(sleep_in_n), .fault_n(fault_n));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= `MFP_HSIZE_WORD;
      do @(posedge core_clk); while (hrdyo !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hrdyo !== 1'b1);
      v = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(v, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      cyc(20000);
      bad_count++;
      print_verdict;
   end
   initial begin
      {nrst, hsel, hwrite, otw_in, thermal_shutdown_flag_in, sense_ref_low_flag_in, pump_low_flag_in} = '0;
      {hw_variant_in, mode_pin_in} = '0;
      ce = 1'b1;
      {htrans, hsize, haddr, hwdata, ocp_in, pwm_in} = '0;
      cyc(4);
      nrst <= 1'b1;
      cyc(4);
      rd(`MFP_ADDR_CTRL, 32'h009);
      rd(8'h10, 32'h0);
      chk(hresp, 32'h0);
      chk(en, 6'h3F);
      pump_low_flag_in <= 1'b1;
      cyc(4);
      chk(en, 6'h0E);
      rd(`MFP_ADDR_DEV, 32'h3);
      rd(`MFP_ADDR_SUP, 32'h2);
      pump_low_flag_in <= 1'b0;
      ce <= 1'b0;
      cyc(30);
      chk(en, 6'h0E);
      ce <= 1'b1;
      cyc(30);
      chk(en, 6'h3F);
      rd(`MFP_ADDR_SUP, 32'h0);
      rd(`MFP_ADDR_DEV, 32'h3);
      ahb(1'b1, `MFP_ADDR_CTRL, 32'h1009);
      cyc(1);
      rd(`MFP_ADDR_DEV, 32'h0);
      sense_ref_low_flag_in <= 1'b1;
      cyc(4);
      chk(en, 6'h3F);
      ahb(1'b1, `MFP_ADDR_CTRL, 32'h029);
      cyc(4);
      chk(en, 6'h36);
      rd(`MFP_ADDR_SUP, 32'h1);
      sense_ref_low_flag_in <= 1'b0;
      cyc(30);
      chk(en, 6'h3F);
      rd(`MFP_ADDR_SUP, 32'h0);
      ahb(1'b1, `MFP_ADDR_CTRL, 32'h1009);
      ahb(1'b1, `MFP_ADDR_CTRL, 32'h00A);
      ocp_in <= 6'h1;
      cyc(20);
      ocp_in <= 6'h0;
      cyc(4);
      rd(`MFP_ADDR_DEV, 32'h0);
      ocp_in <= 6'h1;
      for (int i = 0; i < 10; i++) begin
         pwm_in <= ~pwm_in;
         cyc(4);
      end
      ocp_in <= 6'h0;
      rd(`MFP_ADDR_DEV, 32'h0);
      for (int m = 0; m < 5; m++) begin
         ahb(1'b1, `MFP_ADDR_CTRL, 32'h008 | modes[m]);
         ocp_in <= 6'h1;
         cyc(30);
         chk(en, en1[m]);
         rd(`MFP_ADDR_DEV, dv1[m]);
         ocp_in <= 6'h0;
         cyc(50);
         chk(en, en2[m]);
         rd(`MFP_ADDR_DEV, dv2[m]);
         ahb(1'b1, `MFP_ADDR_CTRL, 32'h1008 | modes[m]);
         cyc(3);
         chk(en, 6'h3F);
         rd(`MFP_ADDR_DEV, 32'h0);
      end
      otw_in <= 1'b1;
      cyc(4);
      chk(en, 6'h3F);
      rd(`MFP_ADDR_DEV, 32'h8);
      rd(`MFP_ADDR_THERM, 32'h1);
      otw_in <= 1'b0;
      cyc(3);
      rd(`MFP_ADDR_THERM, 32'h0);
      rd(`MFP_ADDR_DEV, 32'h8);
      ahb(1'b1, `MFP_ADDR_CTRL, 32'h049);
      otw_in <= 1'b1;
      cyc(4);
      chk(en, 6'h3E);
      otw_in <= 1'b0;
      cyc(3);
      chk(en, 6'h3F);
      ahb(1'b1, `MFP_ADDR_CTRL, 32'h001);
      thermal_shutdown_flag_in <= 1'b1;
      cyc(4);
      chk(en, 6'h0E);
      rd(`MFP_ADDR_THERM, 32'h2);
      thermal_shutdown_flag_in <= 1'b0;
      cyc(30);
      chk(en, 6'h0E);
      cyc(20);
      chk(en, 6'h3F);
      rd(`MFP_ADDR_DEV, 32'h9);
      ctl.reset_pulse(2);
      rd(`MFP_ADDR_DEV, 32'h0);
      chk(en, 6'h3F);
      ctl.set_sleep(1'b0);
      cyc(24);
      chk(en, 6'h01);
      ctl.set_sleep(1'b1);
      cyc(3);
      chk(en, 6'h16);
      cyc(20);
      chk(en, 6'h3F);
      nrst <= 1'b0;
      hw_variant_in <= 1'b1;
      mode_pin_in <= 1'b1;
      cyc(4);
      nrst <= 1'b1;
      cyc(4);
      chk(hresp, 32'h0);
      chk(thr, 32'h1);
      mode_pin_in <= 1'b0;
      cyc(2);
      chk(thr, 32'h0);
      ahb(1'b1, `MFP_ADDR_CTRL, 32'h06A);
      sense_ref_low_flag_in <= 1'b1;
      otw_in <= 1'b1;
      cyc(4);
      chk(en, 6'h3F);
      sense_ref_low_flag_in <= 1'b0;
      otw_in <= 1'b0;
      ocp_in <= 6'h1;
      cyc(30);
      chk(en, 6'h1E);
      rd(`MFP_ADDR_DEV, 32'h10D);
      ocp_in <= 6'h0;
      cyc(30);
      chk(en, 6'h3F);
      print_verdict;
   end
endmodule
`default_nettype wire
